// *** src/scs_pkg.sv ***
// scs_pkg: register map, field positions, reset values and state carriers
// for the serializer control and status block.
// assumes one core clock; pixel clock, video, power-down, strap, remote interrupt and fault pins are synchronised inside the block.
package scs_pkg;
	localparam logic [7:0] A_GEN  = 8'h03;
	localparam logic [7:0] A_PCFG = 8'h05;
	localparam logic [7:0] A_LINK = 8'h0C;
	localparam logic [7:0] A_PSEL = 8'h1E;
	localparam logic [7:0] A_ICTL = 8'hC6;
	localparam logic [7:0] A_ISTS = 8'hC7;

	localparam int B_SEL0   = 0;
	localparam int B_SEL1   = 1;
	localparam int B_ADR2   = 2;
	localparam int B_MAP    = 2;
	localparam int B_FILT   = 4;
	localparam int B_IEN    = 0;
	localparam int B_ICRC   = 1;
	localparam int B_IREM   = 5;
	localparam int B_DET    = 0;
	localparam int B_RATE   = 1;
	localparam int BYTE_MSB = 7;

	localparam logic [7:0]  GEN_RST   = 8'h10;
	localparam logic [1:0]  FILT_LAST = 2'h2;
	localparam int          PAY_HALF  = 17;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	typedef struct packed {
		logic [23:0] rgb;
		logic        hs;
		logic        vs;
		logic        de;
		logic [3:0]  gpio;
		logic [1:0]  aud;
		logic        ctl;
	} scs_vid_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [3:0] gpio;
		logic [3:0] crc;
	} scs_bc_t;

	typedef struct packed {
		logic [2:0] pclk;
		scs_vid_t   v1;
		scs_vid_t   v2;
		logic [1:0] pdn;
		logic [1:0] strap;
		logic [2:0] rem;
		logic [1:0] flt1;
		logic [1:0] flt2;
	} scs_sync_t;

	typedef struct packed {
		logic [7:0]       gen;
		logic [7:0]       psel;
		logic [7:0]       ictl;
		logic [7:0]       ists;
		logic [1:0][7:0]  pcfg;
		logic [1:0]       det;
		logic             map_ld;
		logic [1:0]       cf;
		logic [1:0][1:0]  cnt;
		logic [15:0]      lfsr;
		logic [34:0]      sym;
		logic             sym_v;
		logic [7:0]       rdata;
		logic             rvalid;
		logic             irq_n;
		logic             mirr_n;
		logic [3:0]       bc_gpio;
		logic [7:0]       bc_ctrl;
		logic [1:0]       bc_rate;
		logic             bc_v;
	} scs_core_t;

	typedef struct packed {
		scs_sync_t sy;
		scs_core_t c;
	} scs_state_t;

	localparam scs_core_t CORE_RST = '{gen: GEN_RST, irq_n: 1'h1,
		mirr_n: 1'h1, lfsr: LFSR_SEED, default: '0};
	localparam scs_sync_t SYNC_RST = '{rem: 3'h7, default: '0};

	function automatic logic [3:0] scs_crc(input scs_bc_t f);
		return f.ctrl[7:4] ^ f.ctrl[3:0] ^ f.gpio;
	endfunction
endpackage

// *** src/scs_top.sv ***
// scs_top: serializer control/status: port-select register access,
// sync filter, colour mapping, symbol build, link fault and interrupts.
// assumes register and back-channel ports come from core_clk logic.
`timescale 1ns/1ps
module scs_top (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              pixel_clk,
	input  wire scs_pkg::scs_vid_t video_in,
	input  wire logic              power_down_n,
	input  wire logic              colour_map_strap,
	input  wire logic              remote_irq_in_n,
	input  wire logic [1:0]        port_fault,
	input  wire logic              bc_valid,
	input  wire scs_pkg::scs_bc_t  bc_frame,
	input  wire logic [1:0]        bc_rate,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic              reg_alt,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [34:0]       symbol,
	output logic                   symbol_valid,
	output logic      [7:0]        reg_rdata,
	output logic                   reg_rvalid,
	output logic                   irq_out_n,
	output logic                   remote_irq_mirror_n,
	output logic      [3:0]        bc_gpio_out,
	output logic      [7:0]        bc_ctrl_out,
	output logic                   bc_ctrl_valid
);
	scs_pkg::scs_state_t q;
	scs_pkg::scs_state_t n;
	scs_pkg::scs_vid_t   pl;
	logic                pe;
	logic                rem_fall;
	logic                link_up;
	logic                acc_ok;
	logic                ridx;
	logic                isr_rd;
	logic                bc_bad;
	logic [1:0]          wmask;
	logic [1:0]          raw;
	logic [23:0]         mapped;
	logic [33:0]         scr;

	////////////////////////////////////////////////////////////////////////
	// pixel clock is only sampled; edge seen on the second stage
	assign pe = q.sy.pclk[1] & ~q.sy.pclk[2];
	assign rem_fall = q.sy.rem[2] & ~q.sy.rem[1];
	assign link_up = |q.c.det;
	assign raw = {q.sy.v2.de, q.sy.v2.hs};
	assign bc_bad = bc_frame.crc != scs_pkg::scs_crc(bc_frame);

	// second address with the enable off is not ours: no answer at all
	assign acc_ok = ~reg_alt | q.c.psel[scs_pkg::B_ADR2];
	assign ridx = q.c.psel[scs_pkg::B_ADR2] ? reg_alt
		: q.c.psel[scs_pkg::B_SEL1];
	assign wmask = q.c.psel[scs_pkg::B_ADR2] ? {reg_alt, ~reg_alt}
		: {q.c.psel[scs_pkg::B_SEL1], q.c.psel[scs_pkg::B_SEL0]};
	assign isr_rd = reg_rd & acc_ok & (reg_addr == scs_pkg::A_ISTS);

	// lsb mapping reverses bit order inside each colour byte
	for (genvar i = 0; i < 24; i++) begin : g_map
		assign mapped[i] = q.c.gen[scs_pkg::B_MAP]
			? q.sy.v2.rgb[i ^ scs_pkg::BYTE_MSB] : q.sy.v2.rgb[i];
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = q;
		n.sy.pclk = {q.sy.pclk[1:0], pixel_clk};
		n.sy.v1 = video_in;
		n.sy.v2 = q.sy.v1;
		n.sy.pdn = {q.sy.pdn[0], power_down_n};
		n.sy.strap = {q.sy.strap[0], colour_map_strap};
		n.sy.rem = {q.sy.rem[1:0], remote_irq_in_n};
		n.sy.flt1 = port_fault;
		n.sy.flt2 = q.sy.flt1;
		n.c.sym_v = 1'h0;
		n.c.rvalid = 1'h0;
		n.c.bc_v = 1'h0;

		// strap caught once after reset; software may override later
		if (!q.c.map_ld) begin
			n.c.gen[scs_pkg::B_MAP] = q.sy.strap[1];
			n.c.map_ld = 1'h1;
		end

		// index 0 is horizontal sync, index 1 is data enable
		if (pe) begin
			for (int i = 0; i < 2; i++) begin
				if (!q.c.gen[scs_pkg::B_FILT]) begin
					n.c.cf[i] = raw[i];
					n.c.cnt[i] = 2'h0;
				end else if (raw[i] == q.c.cf[i]) begin
					n.c.cnt[i] = 2'h0;
				end else if (q.c.cnt[i] == scs_pkg::FILT_LAST) begin
					n.c.cf[i] = raw[i];
					n.c.cnt[i] = 2'h0;
				end else begin
					n.c.cnt[i] = q.c.cnt[i] + 2'h1;
				end
			end
		end

		pl = q.sy.v2;
		pl.rgb = mapped;
		pl.hs = n.c.cf[0];
		pl.de = n.c.cf[1];
		scr = pl ^ {q.c.lfsr, q.c.lfsr, q.c.lfsr[1:0]};
		if (pe) begin
			n.c.lfsr = {1'h0, q.c.lfsr[15:1]}
				^ (q.c.lfsr[0] ? scs_pkg::LFSR_TAPS : 16'h0000);
			n.c.sym_v = 1'h1;
			// invert a heavy word and flag it, keeping the line balanced
			if ($countones(scr) > scs_pkg::PAY_HALF) begin
				n.c.sym = {1'h1, ~scr};
			end else begin
				n.c.sym = {1'h0, scr};
			end
		end

		if (bc_valid && !bc_bad) begin
			n.c.bc_gpio = bc_frame.gpio;
			n.c.bc_ctrl = bc_frame.ctrl;
			n.c.bc_rate = bc_rate;
			n.c.bc_v = 1'h1;
		end

		if (reg_wr && acc_ok) begin
			case (reg_addr)
				scs_pkg::A_GEN:  n.c.gen = reg_wdata;
				scs_pkg::A_PSEL: n.c.psel = reg_wdata;
				scs_pkg::A_ICTL: n.c.ictl = reg_wdata;
				scs_pkg::A_PCFG: begin
					for (int p = 0; p < 2; p++) begin
						if (wmask[p]) begin
							n.c.pcfg[p] = reg_wdata;
						end
					end
				end
				default: ;
			endcase
		end

		if (reg_rd && acc_ok) begin
			n.c.rvalid = 1'h1;
			n.c.rdata = 8'h00;
			case (reg_addr)
				scs_pkg::A_GEN:  n.c.rdata = q.c.gen;
				scs_pkg::A_PSEL: n.c.rdata = q.c.psel;
				scs_pkg::A_ICTL: n.c.rdata = q.c.ictl;
				scs_pkg::A_ISTS: n.c.rdata = q.c.ists;
				scs_pkg::A_PCFG: n.c.rdata = q.c.pcfg[ridx];
				scs_pkg::A_LINK: begin
					n.c.rdata[scs_pkg::B_DET] = q.c.det[ridx];
					n.c.rdata[scs_pkg::B_RATE +: 2] = q.c.bc_rate;
				end
				default: n.c.rdata = 8'h00;
			endcase
		end

		// any fault kind gives the same answer: no link detected
		n.c.det = ~q.sy.flt2;
		// set after clear, so an edge in the read cycle is kept
		if (isr_rd) begin
			n.c.ists = 8'h00;
		end
		if (rem_fall && link_up && q.c.ictl[scs_pkg::B_IREM]) begin
			n.c.ists[scs_pkg::B_IREM] = 1'h1;
		end
		if (bc_valid && bc_bad && q.c.ictl[scs_pkg::B_ICRC]) begin
			n.c.ists[scs_pkg::B_ICRC] = 1'h1;
		end
		n.c.irq_n = ~(q.c.ictl[scs_pkg::B_IEN] & |n.c.ists);
		n.c.mirr_n = link_up ? q.sy.rem[1] : 1'h1;

		if (!q.sy.pdn[1]) begin
			n.c = scs_pkg::CORE_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= '{sy: scs_pkg::SYNC_RST, c: scs_pkg::CORE_RST};
		end else begin
			q <= n;
		end
	end

	assign symbol = q.c.sym;
	assign symbol_valid = q.c.sym_v;
	assign reg_rdata = q.c.rdata;
	assign reg_rvalid = q.c.rvalid;
	assign irq_out_n = q.c.irq_n;
	assign remote_irq_mirror_n = q.c.mirr_n;
	assign bc_gpio_out = q.c.bc_gpio;
	assign bc_ctrl_out = q.c.bc_ctrl;
	assign bc_ctrl_valid = q.c.bc_v;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset || !q.sy.pdn[1]);

	symbol_rate_a: assert property (
		pe |=> symbol_valid ##1 !symbol_valid)
		else $error("symbol not issued once per pixel clock");
	bc_frame_a: assert property (
		bc_valid && !bc_bad |=> bc_ctrl_valid
			&& bc_ctrl_out == $past(bc_frame.ctrl))
		else $error("good back-channel frame not taken");
	shared_reg_a: assert property (
		reg_wr && !reg_alt && reg_addr == scs_pkg::A_GEN
			&& q.c.psel[1:0] == 2'h0 |=> q.c.gen == $past(reg_wdata))
		else $error("shared register not written");
	read_port1_a: assert property (
		reg_rd && !reg_alt && reg_addr == scs_pkg::A_PCFG
			&& q.c.psel[2:0] == 3'h3 |=> reg_rvalid
			&& reg_rdata == $past(q.c.pcfg[1]))
		else $error("read with both selects not from port 1");
	write_both_a: assert property (
		reg_wr && !reg_alt && reg_addr == scs_pkg::A_PCFG
			&& q.c.psel[2:0] == 3'h3 |=> q.c.pcfg[0] == $past(reg_wdata)
			&& q.c.pcfg[1] == $past(reg_wdata))
		else $error("write with both selects missed a port");
	second_addr_a: assert property (
		reg_wr && reg_alt && q.c.psel[2:0] == 3'h5
			&& reg_addr == scs_pkg::A_PCFG |=> $stable(q.c.pcfg[0])
			&& q.c.pcfg[1] == $past(reg_wdata))
		else $error("second address did not reach port 1 only");
	filter_hold_a: assert property (
		pe && q.c.gen[4] && raw[0] != q.c.cf[0] && q.c.cnt[0] != 2'h2
			|=> $stable(q.c.cf[0]))
		else $error("filter passed a short sync pulse");
	filter_pass_a: assert property (
		pe && q.c.gen[4] && raw[1] != q.c.cf[1] && q.c.cnt[1] == 2'h2
			|=> $changed(q.c.cf[1]))
		else $error("filter held a stable enable level");
	filter_off_a: assert property (
		pe && !q.c.gen[4] |=> q.c.cf == $past(raw))
		else $error("disabled filter did not pass level");
	pd_reset_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!q.sy.pdn[1] |=> q.c == scs_pkg::CORE_RST)
		else $error("power-down did not restore defaults");
	fault_det_a: assert property (
		q.sy.flt2[0] |=> !q.c.det[0])
		else $error("fault left link detect set");
	rem_irq_a: assert property (
		rem_fall && link_up && q.c.ictl[5] && q.c.ictl[0] && !reg_wr
			|=> q.c.ists[5] && !irq_out_n)
		else $error("remote interrupt not raised");
	isr_clear_a: assert property (
		isr_rd && !rem_fall && !bc_valid |=> q.c.ists == 8'h00 && irq_out_n)
		else $error("status read did not release interrupt");
	no_edge_a: assert property (
		!rem_fall && !q.c.ists[5] |=> !q.c.ists[5])
		else $error("remote interrupt without falling edge");
	mirror_a: assert property (
		!link_up |=> remote_irq_mirror_n)
		else $error("mirror low without link");

	rem_irq_c: cover property (rem_fall && link_up ##1 !irq_out_n);
	both_wr_c: cover property (reg_wr && wmask == 2'h3);
	filt_c: cover property (pe && q.c.cnt[0] == 2'h2);
	alt_rd_c: cover property (reg_rd && reg_alt && acc_ok);
endmodule

// *** verification/scs_des_model.sv ***
// scs_des_model: far-side deserializer driving back-channel frames,
// the remote interrupt pin and the interconnect fault levels.
// assumes the bench calls its tasks; changes land 1 ns after core_clk.
`timescale 1ns/1ps
module scs_des_model (
	input  wire logic        core_clk,
	output logic             remote_irq_in_n,
	output logic [1:0]       port_fault,
	output logic             bc_valid,
	output scs_pkg::scs_bc_t bc_frame,
	output logic [1:0]       bc_rate
);
	initial begin
		remote_irq_in_n = 1'b1;
		port_fault = 2'b00;
		bc_valid = 1'b0;
		bc_frame = '0;
		bc_rate = 2'b00;
	end
	////////////////////////////////////////////////////////////////////
	// bad flips one check bit so the frame must be dropped
	task automatic send(input logic [7:0] c, input logic [3:0] g,
		input logic [1:0] r, input logic bad);
		@(posedge core_clk) #1;
		bc_frame.ctrl = c;
		bc_frame.gpio = g;
		bc_frame.crc = c[7:4] ^ c[3:0] ^ g ^ {3'b000, bad};
		bc_rate = r;
		bc_valid = 1'b1;
		@(posedge core_clk) #1;
		bc_valid = 1'b0;
		// between frames the lines carry junk, not the last value
		bc_frame = ~bc_frame;
		bc_rate = ~bc_rate;
	endtask
	task automatic pin(input logic irq_n, input logic [1:0] flt);
		@(posedge core_clk) #1;
		remote_irq_in_n = irq_n;
		port_fault = flt;
	endtask
endmodule

// *** verification/serializer_ctrl_status_bench.sv ***
// serializer_ctrl_status_bench: directed scenarios for scs_top.
// assumes scs_des_model as far side; bench plays host and pixel source.
`timescale 1ns/1ps
module serializer_ctrl_status_bench;
	logic             core_clk = 1'b0;
	logic             reset = 1'b1;
	logic             pixel_clk = 1'b0;
	logic [33:0]      vid = '0;
	logic             power_down_n = 1'b1;
	logic             strap = 1'b0;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic             reg_alt = 1'b0;
	logic [7:0]       reg_addr = '0;
	logic [7:0]       reg_wdata = '0;
	logic [34:0]      symbol;
	logic [7:0]       rdata, bc_ctrl;
	logic [3:0]       bc_gpio;
	logic [1:0]       flt, bcr;
	logic             sym_v, rvalid, irq_n, mirr_n, bc_v, rin_n, bcv;
	scs_pkg::scs_bc_t bcf;
	int               n_mismatch = 0;
	int               n_compared = 0;

	always #5 core_clk = ~core_clk;
	// offset start keeps pixel edges away from core edges
	// slow pixel clock: the core must see every pixel edge
	initial begin
		#3;
		forever #62.5 pixel_clk = ~pixel_clk;
	end
	// only colour changes; syncs stay put
	always @(negedge pixel_clk) vid[33:10] <= vid[33:10] + 24'h1;

	scs_top dut (.core_clk(core_clk), .reset(reset), .pixel_clk(pixel_clk),
		.video_in(vid), .power_down_n(power_down_n),
		.colour_map_strap(strap), .remote_irq_in_n(rin_n),
		.port_fault(flt), .bc_valid(bcv), .bc_frame(bcf), .bc_rate(bcr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_alt(reg_alt),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .symbol(symbol),
		.symbol_valid(sym_v), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.irq_out_n(irq_n), .remote_irq_mirror_n(mirr_n),
		.bc_gpio_out(bc_gpio), .bc_ctrl_out(bc_ctrl),
		.bc_ctrl_valid(bc_v));
	scs_des_model des (.core_clk(core_clk), .remote_irq_in_n(rin_n),
		.port_fault(flt), .bc_valid(bcv), .bc_frame(bcf), .bc_rate(bcr));

	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic alt);
		@(posedge core_clk) #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		reg_alt = alt;
		@(posedge core_clk) #1;
		reg_wr = 1'b0;
	endtask
	// v: answer expected; m masks bits not under test
	task automatic rd(input logic [7:0] a, input logic alt, input logic v,
		input logic [7:0] m, input logic [7:0] e);
		@(posedge core_clk) #1;
		reg_rd = 1'b1;
		reg_addr = a;
		reg_alt = alt;
		@(posedge core_clk) #1;
		reg_rd = 1'b0;
		chk({7'h0, rvalid}, {7'h0, v});
		chk(rdata & m, e);
	endtask
	task automatic settle();
		repeat (5) @(posedge core_clk);
		#1;
	endtask
	// hs and de move together, then hold for p pixel periods
	task automatic sync_lvl(input logic v, input int p);
		@(negedge pixel_clk);
		@(posedge core_clk) #1;
		vid[9] = v;
		vid[7] = v;
		repeat (p) @(negedge pixel_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h03, 1'b0, 1'b1, 8'hFF, 8'h10);
		rd(8'hC6, 1'b0, 1'b1, 8'hFF, 8'h00);
		rd(8'hC7, 1'b0, 1'b1, 8'hFF, 8'h00);
		rd(8'h0C, 1'b0, 1'b1, 8'h01, 8'h01);
		rd(8'h7F, 1'b0, 1'b1, 8'hFF, 8'h00);
		chk({6'h0, irq_n, mirr_n}, 8'h03);
	endtask
	task automatic t_ports();
		wr(8'h1E, 8'h03, 1'b0);
		wr(8'h05, 8'hA5, 1'b0);
		wr(8'h1E, 8'h01, 1'b0);
		rd(8'h05, 1'b0, 1'b1, 8'hFF, 8'hA5);
		wr(8'h05, 8'h11, 1'b0);
		wr(8'h1E, 8'h03, 1'b0);
		rd(8'h05, 1'b0, 1'b1, 8'hFF, 8'hA5);
		wr(8'h1E, 8'h00, 1'b0);
		wr(8'h05, 8'hFF, 1'b0);
		rd(8'h03, 1'b0, 1'b1, 8'hFF, 8'h10);
		wr(8'h1E, 8'h01, 1'b0);
		rd(8'h05, 1'b0, 1'b1, 8'hFF, 8'h11);
	endtask
	task automatic t_alt();
		wr(8'h1E, 8'h06, 1'b0);
		wr(8'h05, 8'h22, 1'b1);
		rd(8'h05, 1'b0, 1'b1, 8'hFF, 8'h11);
		rd(8'h05, 1'b1, 1'b1, 8'hFF, 8'h22);
		wr(8'h1E, 8'h00, 1'b0);
		rd(8'h05, 1'b1, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic t_link();
		des.pin(1'b1, 2'b01);
		settle();
		rd(8'h0C, 1'b0, 1'b1, 8'h01, 8'h00);
		wr(8'h1E, 8'h02, 1'b0);
		rd(8'h0C, 1'b0, 1'b1, 8'h01, 8'h01);
		des.pin(1'b0, 2'b11);
		settle();
		chk({6'h0, irq_n, mirr_n}, 8'h03);
		des.pin(1'b1, 2'b00);
		wr(8'h1E, 8'h00, 1'b0);
	endtask
	task automatic t_irq();
		wr(8'hC6, 8'h21, 1'b0);
		des.pin(1'b0, 2'b00);
		settle();
		chk({6'h0, irq_n, mirr_n}, 8'h00);
		rd(8'hC7, 1'b0, 1'b1, 8'h20, 8'h20);
		chk({7'h0, irq_n}, 8'h01);
		settle();
		chk({7'h0, irq_n}, 8'h01);
		des.pin(1'b1, 2'b00);
		settle();
		des.pin(1'b0, 2'b00);
		settle();
		chk({7'h0, irq_n}, 8'h00);
		rd(8'hC7, 1'b0, 1'b1, 8'h20, 8'h20);
		des.pin(1'b1, 2'b00);
		wr(8'hC6, 8'h20, 1'b0);
		des.pin(1'b0, 2'b00);
		settle();
		chk({7'h0, irq_n}, 8'h01);
		rd(8'hC7, 1'b0, 1'b1, 8'h20, 8'h20);
		des.pin(1'b1, 2'b00);
	endtask
	task automatic t_bc();
		des.send(8'h5A, 4'h9, 2'h2, 1'b0);
		chk({7'h0, bc_v}, 8'h01);
		chk({bc_gpio, 4'h0} ^ bc_ctrl, 8'hCA);
		rd(8'h0C, 1'b0, 1'b1, 8'h06, 8'h04);
		wr(8'hC6, 8'h02, 1'b0);
		des.send(8'hA5, 4'h3, 2'h1, 1'b1);
		chk({7'h0, bc_v}, 8'h00);
		chk(bc_ctrl, 8'h5A);
		rd(8'hC7, 1'b0, 1'b1, 8'h02, 8'h02);
	endtask
	task automatic t_pdn();
		wr(8'h03, 8'h00, 1'b0);
		wr(8'hC6, 8'h21, 1'b0);
		strap = 1'b1;
		power_down_n = 1'b0;
		settle();
		power_down_n = 1'b1;
		settle();
		rd(8'h03, 1'b0, 1'b1, 8'hFF, 8'h14);
		rd(8'hC6, 1'b0, 1'b1, 8'hFF, 8'h00);
	endtask
	// each pulse is followed by 130 quiet pixel periods
	task automatic t_filt();
		sync_lvl(1'b1, 1);
		chk({6'h0, dut.q.c.cf}, 8'h00);
		sync_lvl(1'b0, 130);
		chk({6'h0, dut.q.c.cf}, 8'h00);
		sync_lvl(1'b1, 4);
		chk({6'h0, dut.q.c.cf}, 8'h03);
		sync_lvl(1'b0, 130);
		chk({6'h0, dut.q.c.cf}, 8'h00);
		wr(8'h03, 8'h04, 1'b0);
		sync_lvl(1'b1, 1);
		chk({6'h0, dut.q.c.cf}, 8'h03);
		sync_lvl(1'b0, 130);
		chk({6'h0, dut.q.c.cf}, 8'h00);
		wr(8'h03, 8'h14, 1'b0);
	endtask
	// 500 core cycles hold exactly 40 pixel periods
	task automatic t_sym();
		int n;
		n = 0;
		repeat (500) begin
			@(posedge core_clk) #1;
			if (sym_v === 1'b1) begin
				n++;
				chk({7'h0, $countones(symbol[33:0]) > 17}, 8'h00);
			end
		end
		chk(8'(n), 8'd40);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		#1;
		reset = 1'b0;
		settle();
		t_reset();
		t_ports();
		t_alt();
		t_link();
		t_irq();
		t_bc();
		t_pdn();
		t_filt();
		t_sym();
		wrap_up();
	end
endmodule
